/* lpmc_map.svh */
// constants of the low power mode controller
// assumes a 40 MHz core clock
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH

// ----------------------------------------------------------------------
// mode select codes
// ----------------------------------------------------------------------
`define LPMC_SEL_RUN       3'h0
`define LPMC_SEL_STOP0     3'h1
`define LPMC_SEL_STOP1     3'h2
`define LPMC_SEL_STANDBY   3'h3
`define LPMC_SEL_SHUTDOWN  3'h4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LPMC_CLK_MHZ        40
`define LPMC_SLEEP_CYC      9
`define LPMC_STOP0_NS       1700
`define LPMC_STOP1_NS       4700
`define LPMC_STANDBY_NS     51000
// round down to whole cycles
`define LPMC_NS2CYC(ns)     (((ns) * `LPMC_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------
// pull codes per io
// ----------------------------------------------------------------------
`define LPMC_PULL_FLOAT     2'h0
`define LPMC_PULL_UP        2'h1
`define LPMC_PULL_DOWN      2'h2

`endif

/* lpmc_pkg.sv */
// types of the low power mode controller
// assumes lpmc_map.svh is on the include path
package lpmc_pkg;
  typedef enum logic [3:0] {
    LPMC_RUN,
    LPMC_SLEEP,
    LPMC_STOP,
    LPMC_STANDBY,
    LPMC_SHUTDOWN,
    LPMC_WAKE_RESTORE,
    LPMC_WAKE_RELEASE
  } lpmc_state_type;
endpackage

/* lpmc_wake_timer.sv */
// wake-up latency counter: counts a loaded number of cycles to done
// assumes a synchronous active-high reset on the core clock
`timescale 1ns/1ps
module lpmc_wake_timer #(
  parameter int WIDTH = 12
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  busy_o,
  output logic                  done_o
);
  logic [WIDTH-1:0] remain;

  initial begin
    if (WIDTH < 4) $error("wake timer: WIDTH too small");
  end

  // load, count down, pulse done on the last cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      remain <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      remain <= count_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_o) begin
      remain <= remain - 1'b1;
      done_o <= (remain <= WIDTH'(1));
      busy_o <= (remain > WIDTH'(1));
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

/* lpmc_ctrl.sv */
// low power mode controller: mode sequencing, regulator, memories, clocks,
// wake sources and io pull handling
// assumes pins are asynchronous, all else on the core clock
//
// Functional notes
// RULE1 - optional peripherals start disabled until software enables them
// RULE2 - radio powered in standby only with sram retention selected
// RULE3 - stop: requests start 16 MHz oscillator, fed only to requester
// RULE4 - on-demand 16 MHz oscillator turns off once no request remains
// RULE5 - serial receiver wakes on start bit, address match or frame in stop
// RULE6 - two-wire address comparator wakes only on address match in stop
// RULE7 - port A lines zero and two wake from standby and shutdown
// RULE8 - standby holds the pull setting chosen before entry
// RULE9 - shutdown applies chosen pulls, discarded when shutdown ends
// RULE10 - sram block clocks gate independently in sleep modes
// RULE11 - flash power-down only with radio idle and code in sram
// RULE12 - stop modes enable 32 MHz oscillator whenever radio needs it
// RULE13 - low-power run/sleep use low-power regulator; radio, rng, pll off
// RULE14 - sleep stops processor only; any event wakes within 9 cycles (code wakes sleep on irq_i only)
// RULE15 - stop 0: main regulator on, cpu and flash off, wake 1.7 us
// RULE16 - stop 1: low-power regulator, processor and flash off, wake 4.7 us
// RULE17 - standby wakes by reset pin, wake pins, brownout, clock, watchdog
// RULE18 - standby powers off all but wake sources, wakes in 51 us
// RULE19 - shutdown keeps only slow crystal and clock; pins, clock, reset wake (code also runs the 32 MHz oscillator there on radio_rf_need_i)
// RULE20 - ios held analog, triggers off, under reset until reconfigured
// RULE21 - reset pin pull-up off for internal reset sources
// RULE22 - wake restores regulator, flash, clocks before cpu release
// RULE23 - software selects mode before wait and requests only legal modes
`timescale 1ns/1ps
`include "lpmc_map.svh"
module lpmc_ctrl
  import lpmc_pkg::*;
#(
  parameter int N_IO   = 8,
  parameter int N_HREQ = 4,
  parameter int STANDBY_CYC = `LPMC_NS2CYC(`LPMC_STANDBY_NS)
) (
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  // software controls
  input  wire logic [2:0]        mode_sel_i,
  input  wire logic              low_power_i,
  input  wire logic              wait_i,
  input  wire logic              sram_retain_i,
  input  wire logic              sram_block_one_gate_i,
  input  wire logic              sram_block_two_gate_i,
  input  wire logic              flash_pd_req_i,
  input  wire logic              code_in_sram_i,
  input  wire logic [4:0]        opt_en_i,
  input  wire logic              io_cfg_wr_i,
  input  wire logic [2*N_IO-1:0] io_pull_i,
  // events and requests
  input  wire logic              irq_i,
  input  wire logic              radio_busy_i,
  input  wire logic              radio_rf_need_i,
  input  wire logic [N_HREQ-1:0] hsi_req_i,
  input  wire logic              ser_start_i,
  input  wire logic              ser_addr_i,
  input  wire logic              ser_frame_i,
  input  wire logic              twi_addr_i,
  input  wire logic              lptim_wake_i,
  input  wire logic              rtc_wake_i,
  input  wire logic              independent_watchdog_wake_i,
  input  wire logic              bor_wake_i,
  input  wire logic              port_a_line_zero_i,
  input  wire logic              port_a_line_two_i,
  input  wire logic              rst_pin_n_i,
  input  wire logic              int_reset_i,
  // outputs
  output logic                   main_regulator_o,
  output logic                   low_power_regulator_o,
  output logic                   cpu_run_o,
  output logic                   flash_on_o,
  output logic                   sram_on_o,
  output logic                   sram_block_one_clk_o,
  output logic                   sram_block_two_clk_o,
  output logic                   radio_pwr_o,
  output logic                   rng_en_o,
  output logic                   pll_en_o,
  output logic                   periph_run_o,
  output logic [4:0]             opt_active_o,
  output logic                   internal_16mhz_oscillator_o,
  output logic [N_HREQ-1:0]      hsi_grant_o,
  output logic                   external_32mhz_oscillator_o,
  output logic                   low_speed_osc_o,
  output logic                   wake_irq_o,
  output logic [3:0]             wake_src_o,
  output logic [2*N_IO-1:0]      io_pull_o,
  output logic                   io_analog_o,
  output logic                   rst_pullup_o
);
  initial begin
    if (N_IO < 3) $error("N_IO must cover port A line two");
    if (N_HREQ < 1) $error("N_HREQ must be at least one");
  end

  // ----------------------------------------------------------------------
  // latency counts
  // ----------------------------------------------------------------------
  localparam int STOP0_CYC = `LPMC_NS2CYC(`LPMC_STOP0_NS);
  localparam int STOP1_CYC = `LPMC_NS2CYC(`LPMC_STOP1_NS);
  localparam int TW = 12;
  initial begin
    if (STANDBY_CYC < 1 || STANDBY_CYC >= (1 << TW))
      $error("STANDBY_CYC out of range");
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       wk0;
  logic       wk2;
  logic       rst_pin_n;
  logic       rtc_sync;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_meta <= 4'h2;
      pin_sync <= 4'h2;
    end else begin
      pin_meta <= {port_a_line_zero_i, port_a_line_two_i, rst_pin_n_i,
                   rtc_wake_i};
      pin_sync <= pin_meta;
    end
  end
  assign wk0       = pin_sync[3];
  assign wk2       = pin_sync[2];
  assign rst_pin_n = pin_sync[1];
  assign rtc_sync  = pin_sync[0];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  lpmc_state_type state;
  lpmc_state_type next_state;
  logic [2:0]     mode;
  logic           in_sleep;
  logic           in_stop;
  logic           stop_wake;
  logic           sb_wake;
  logic           sd_wake;
  logic           sleep_wake;
  logic [3:0]     next_src;
  logic           tmr_load;
  logic [TW-1:0]  tmr_count;
  logic           tmr_done;
  logic [3:0]     sleep_cnt;

  assign in_sleep = (state == LPMC_SLEEP);
  assign in_stop  = (state == LPMC_STOP);

  // RULE5 serial receiver wake
  // RULE6 address-only wake
  assign stop_wake = ser_start_i | ser_addr_i | ser_frame_i | twi_addr_i |
                     lptim_wake_i | rtc_sync | independent_watchdog_wake_i | bor_wake_i |
                     radio_rf_need_i | irq_i | ~rst_pin_n;
  // RULE7 dedicated wake lines
  // RULE17 standby wake sources
  assign sb_wake = wk0 | wk2 | ~rst_pin_n | bor_wake_i | rtc_sync |
                   independent_watchdog_wake_i;
  // RULE19 shutdown wake sources
  assign sd_wake = wk0 | wk2 | ~rst_pin_n | rtc_sync;
  // RULE14 wake on the interrupt input irq_i only
  assign sleep_wake = irq_i;

  // wake source code: 1 serial, 2 two-wire, 3 pin, 4 other
  always_comb begin
    next_src = 4'h4;
    if (ser_start_i | ser_addr_i | ser_frame_i) begin
      next_src = 4'h1;
    end else if (twi_addr_i) begin
      next_src = 4'h2;
    end else if (wk0 | wk2) begin
      next_src = 4'h3;
    end
  end

  // mode sequencing
  // RULE23 mode chosen before wait
  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_count  = TW'(STOP0_CYC);
    case (state)
      LPMC_RUN: begin
        if (wait_i) begin
          case (mode_sel_i)
            `LPMC_SEL_STOP0, `LPMC_SEL_STOP1: next_state = LPMC_STOP;
            `LPMC_SEL_STANDBY:                next_state = LPMC_STANDBY;
            `LPMC_SEL_SHUTDOWN:               next_state = LPMC_SHUTDOWN;
            default:                          next_state = LPMC_SLEEP;
          endcase
        end
      end
      LPMC_SLEEP: begin
        if (sleep_wake) begin
          next_state = LPMC_WAKE_RELEASE;
        end
      end
      // RULE15 stop 0 latency
      // RULE16 stop 1 latency
      LPMC_STOP: begin
        if (stop_wake) begin
          next_state = LPMC_WAKE_RESTORE;
          tmr_load   = 1'b1;
          tmr_count  = (mode == `LPMC_SEL_STOP1) ? TW'(STOP1_CYC)
                                                  : TW'(STOP0_CYC);
        end
      end
      // RULE18 standby wake latency
      LPMC_STANDBY: begin
        if (sb_wake) begin
          next_state = LPMC_WAKE_RESTORE;
          tmr_load   = 1'b1;
          tmr_count  = TW'(STANDBY_CYC);
        end
      end
      LPMC_SHUTDOWN: begin
        if (sd_wake) begin
          next_state = LPMC_WAKE_RESTORE;
          tmr_load   = 1'b1;
          tmr_count  = TW'(STANDBY_CYC);
        end
      end
      // RULE22 restore before release
      LPMC_WAKE_RESTORE: begin
        if (tmr_done) begin
          next_state = LPMC_RUN;
        end
      end
      LPMC_WAKE_RELEASE: begin
        if (sleep_cnt == 4'h0) begin
          next_state = LPMC_RUN;
        end
      end
      default: next_state = LPMC_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= LPMC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // latch selected mode on entry
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode <= `LPMC_SEL_RUN;
    end else if (state == LPMC_RUN && wait_i) begin
      mode <= mode_sel_i;
    end
  end

  // RULE14 resume within 9 cycles
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sleep_cnt <= 4'h0;
    end else if (in_sleep && sleep_wake) begin
      sleep_cnt <= 4'(`LPMC_SLEEP_CYC - 2);
    end else if (sleep_cnt != 4'h0) begin
      sleep_cnt <= sleep_cnt - 4'h1;
    end
  end

  lpmc_wake_timer #(
    .WIDTH (TW)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (tmr_load),
    .count_i    (tmr_count),
    .busy_o     (),
    .done_o     (tmr_done)
  );

  // ----------------------------------------------------------------------
  // power and clock outputs
  // ----------------------------------------------------------------------
  logic lp_mode;
  logic deep;
  logic off_all;
  assign lp_mode = low_power_i && (state == LPMC_RUN || in_sleep);
  assign deep    = (state == LPMC_STANDBY) || (state == LPMC_SHUTDOWN);
  assign off_all = (state == LPMC_SHUTDOWN);

  // RULE13 regulator choice
  // RULE15 stop 0 main regulator
  // RULE16 stop 1 low-power regulator
  // RULE19 shutdown regulator off
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      main_regulator_o      <= 1'b1;
      low_power_regulator_o <= 1'b0;
    end else begin
      main_regulator_o <= !off_all && !(state == LPMC_STANDBY) &&
                          !lp_mode &&
                          !(in_stop && mode == `LPMC_SEL_STOP1);
      low_power_regulator_o <= lp_mode ||
                               (in_stop && mode == `LPMC_SEL_STOP1) ||
                               (state == LPMC_STANDBY && sram_retain_i);
    end
  end

  // RULE11 flash power-down guard
  // RULE22 flash back before cpu
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cpu_run_o  <= 1'b1;
      flash_on_o <= 1'b1;
      sram_on_o  <= 1'b1;
    end else begin
      cpu_run_o  <= (next_state == LPMC_RUN);
      flash_on_o <= (state == LPMC_RUN || in_sleep ||
                     state == LPMC_WAKE_RELEASE ||
                     (state == LPMC_WAKE_RESTORE)) &&
                    !(flash_pd_req_i && !radio_busy_i && code_in_sram_i &&
                      (state == LPMC_RUN || in_sleep));
      sram_on_o  <= !off_all &&
                    !(state == LPMC_STANDBY && !sram_retain_i);
    end
  end

  // RULE10 independent sram gating
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sram_block_one_clk_o <= 1'b1;
      sram_block_two_clk_o <= 1'b1;
    end else begin
      sram_block_one_clk_o <= !deep && !in_stop &&
                              !(in_sleep && sram_block_one_gate_i);
      sram_block_two_clk_o <= !deep && !in_stop &&
                              !(in_sleep && sram_block_two_gate_i);
    end
  end

  // RULE2 radio in standby
  // RULE13 radio rng pll off
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      radio_pwr_o <= 1'b1;
      rng_en_o    <= 1'b0;
      pll_en_o    <= 1'b0;
    end else begin
      radio_pwr_o <= !off_all && !lp_mode &&
                     !(state == LPMC_STANDBY && !sram_retain_i);
      rng_en_o    <= (state == LPMC_RUN || in_sleep) && !lp_mode;
      pll_en_o    <= (state == LPMC_RUN || in_sleep) && !lp_mode;
    end
  end

  // RULE1 optional peripherals
  // RULE18 standby powers off
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      periph_run_o <= 1'b1;
      opt_active_o <= 5'h00;
    end else begin
      periph_run_o <= (state == LPMC_RUN || in_sleep);
      opt_active_o <= (state == LPMC_RUN || in_sleep || in_stop) ?
                      opt_en_i : 5'h00;
    end
  end

  // RULE3 grant to requester
  // RULE4 auto off
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      internal_16mhz_oscillator_o <= 1'b0;
      hsi_grant_o                 <= '0;
    end else begin
      internal_16mhz_oscillator_o <= in_stop && (|hsi_req_i);
      hsi_grant_o <= in_stop ? hsi_req_i : '0;
    end
  end

  // RULE12 crystal for radio
  // RULE19 slow crystal kept; 32 MHz follows radio_rf_need_i in shutdown
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      external_32mhz_oscillator_o <= 1'b0;
      low_speed_osc_o             <= 1'b1;
    end else begin
      external_32mhz_oscillator_o <= (!periph_run_o && radio_rf_need_i) ||
                                     ((state == LPMC_RUN || in_sleep) &&
                                      !lp_mode && radio_busy_i);
      low_speed_osc_o <= 1'b1;
    end
  end

  // wake report to software
  // RULE22 report wake source
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wake_irq_o <= 1'b0;
      wake_src_o <= 4'h0;
    end else begin
      wake_irq_o <= (state == LPMC_WAKE_RESTORE) && tmr_done;
      if ((in_stop && stop_wake) || (deep && (sb_wake || sd_wake))) begin
        wake_src_o <= next_src;
      end
    end
  end

  // ----------------------------------------------------------------------
  // io handling
  // ----------------------------------------------------------------------
  logic [2*N_IO-1:0] pull_cfg;
  logic              io_cfgd;

  // RULE20 analog until configured
  // RULE9 shutdown discards pulls
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pull_cfg <= '0;
      io_cfgd  <= 1'b0;
    end else if (state == LPMC_SHUTDOWN && next_state != LPMC_SHUTDOWN) begin
      pull_cfg <= '0;
      io_cfgd  <= 1'b0;
    end else if (io_cfg_wr_i && state == LPMC_RUN) begin
      pull_cfg <= io_pull_i;
      io_cfgd  <= 1'b1;
    end
  end

  // RULE8 standby keeps pulls
  // RULE9 shutdown applies pulls
  genvar g;
  generate
    for (g = 0; g < N_IO; g++) begin : g_io
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          io_pull_o[2*g+1:2*g] <= `LPMC_PULL_FLOAT;
        end else begin
          io_pull_o[2*g+1:2*g] <= pull_cfg[2*g+1:2*g];
        end
      end
    end
  endgenerate

  // RULE20 schmitt triggers off
  // RULE21 reset pull-up control
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      io_analog_o  <= 1'b1;
      rst_pullup_o <= 1'b1;
    end else begin
      io_analog_o  <= !io_cfgd;
      rst_pullup_o <= !int_reset_i;
    end
  end
endmodule

/* lpmc_checker.sv */
// concurrent checks on the low power mode controller ports
// assumes it is bound into lpmc_ctrl and sees only its ports
`timescale 1ns/1ps
module lpmc_checker #(
  parameter int N_IO   = 8,
  parameter int N_HREQ = 4
) (
  input wire logic              core_clk_i,
  input wire logic              srst_i,
  input wire logic              low_power_i,
  input wire logic              flash_pd_req_i,
  input wire logic [4:0]        opt_en_i,
  input wire logic              irq_i,
  input wire logic              radio_rf_need_i,
  input wire logic [N_HREQ-1:0] hsi_req_i,
  input wire logic              int_reset_i,
  input wire logic              main_regulator_o,
  input wire logic              low_power_regulator_o,
  input wire logic              cpu_run_o,
  input wire logic              flash_on_o,
  input wire logic              radio_pwr_o,
  input wire logic              rng_en_o,
  input wire logic              pll_en_o,
  input wire logic [4:0]        opt_active_o,
  input wire logic              internal_16mhz_oscillator_o,
  input wire logic [N_HREQ-1:0] hsi_grant_o,
  input wire logic              external_32mhz_oscillator_o,
  input wire logic              wake_irq_o,
  input wire logic              io_analog_o,
  input wire logic              rst_pullup_o
);
  // ------------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  opt_needs_en_a:
    assert property ((opt_active_o & ~(opt_en_i | $past(opt_en_i))) == '0)
    else $error("optional unit not enabled");
  grant_to_req_a:
    assert property (hsi_grant_o != '0 |-> internal_16mhz_oscillator_o
      && (hsi_grant_o & ~(hsi_req_i | $past(hsi_req_i))) == '0)
    else $error("grant without request");
  osc16_idle_off_a:
    assert property ((hsi_req_i == '0) [*3] |-> !internal_16mhz_oscillator_o)
    else $error("16 MHz left on");
  lp_run_off_a:
    assert property ((low_power_i && cpu_run_o) [*3]
      |-> !radio_pwr_o && !rng_en_o && !pll_en_o)
    else $error("rf, rng or pll on in lp run");
  sleep_wake_a:
    assert property (!cpu_run_o && main_regulator_o && flash_on_o && irq_i
      |-> ##[1:9] cpu_run_o)
    else $error("sleep wake too slow");
  restore_first_a:
    assert property ($rose(cpu_run_o) && !low_power_i && !flash_pd_req_i
      |-> main_regulator_o && flash_on_o)
    else $error("cpu before power restored");
  radio_unpowered_a:
    assert property (!main_regulator_o && !low_power_regulator_o
      |-> !radio_pwr_o)
    else $error("radio on, regulators off");
  osc32_on_need_a:
    assert property (radio_rf_need_i && !cpu_run_o && !flash_on_o
      |=> external_32mhz_oscillator_o)
    else $error("32 MHz not on for radio");
  io_reset_analog_a:
    assert property ($past(srst_i) |-> io_analog_o)
    else $error("io not analog after reset");
  pullup_internal_a:
    assert property (int_reset_i [*2] |-> !rst_pullup_o)
    else $error("pull-up on, internal reset");
  wake_pulse_a:
    assert property (wake_irq_o |=> !wake_irq_o)
    else $error("wake pulse too long");
endmodule

bind lpmc_ctrl lpmc_checker #(.N_IO(N_IO), .N_HREQ(N_HREQ)) i_chk (.*);

/* lpmc_partner.sv */
// far side model: wake-capable peripherals, wake pins, interrupt sources
// assumes go_i pulses with an event index
`timescale 1ns/1ps
module lpmc_partner (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        go_i,
  input  wire logic [3:0]  idx_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic        cpu_run_i,
  output logic      [15:0] ev_o
);
  logic       armed;
  logic [3:0] left;
  logic [3:0] pick;

  // raise the chosen event after the delay, hold until cpu runs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      armed <= 1'b0;
      left  <= 4'h0;
      pick  <= 4'h0;
      ev_o  <= 16'h0000;
    end else if (go_i) begin
      armed <= 1'b1;
      left  <= dly_i;
      pick  <= idx_i;
    end else if (armed && left != 4'h0) begin
      left <= left - 4'h1;
    end else if (armed) begin
      armed      <= 1'b0;
      ev_o[pick] <= 1'b1;
    end else if (cpu_run_i) begin
      ev_o <= 16'h0000;
    end
  end
endmodule

/* testbench.sv */
// self-checking bench for the low power mode controller
// assumes design, partner and checker files compiled first
`timescale 1ns/1ps
module testbench;
  localparam int SBY = 8;
  logic clk = 1'b0, srst = 1'b1, wait_s = 1'b0, lp = 1'b0, go = 1'b0;
  logic retain = 1'b0, g1 = 1'b0, g2 = 1'b0, fpd = 1'b0, cfg = 1'b0;
  logic csram = 1'b0, busy = 1'b0, rfn = 1'b0, irst = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic [4:0]  opt_en = 5'h00;
  logic [15:0] pull = 16'h0000;
  logic [3:0]  hreq = 4'h0, idx = 4'h0, dly = 4'h0;
  logic [15:0] ev;
  logic mreg, lpreg, cpu, fl, sram, c1, c2, rpwr, random_number_generator, pll, prun;
  logic osc16, osc32, lso, wirq, ana, rpu;
  logic [4:0]  opt_act;
  logic [3:0]  grant, wsrc;
  logic [15:0] pull_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;

  always #12.5 clk = ~clk;

  lpmc_ctrl #(.N_IO(8), .N_HREQ(4), .STANDBY_CYC(SBY)) i_dut (
    .core_clk_i(clk), .srst_i(srst), .mode_sel_i(mode), .low_power_i(lp),
    .wait_i(wait_s), .sram_retain_i(retain), .sram_block_one_gate_i(g1),
    .sram_block_two_gate_i(g2), .flash_pd_req_i(fpd), .code_in_sram_i(csram),
    .opt_en_i(opt_en), .io_cfg_wr_i(cfg), .io_pull_i(pull), .irq_i(ev[0]),
    .radio_busy_i(busy), .radio_rf_need_i(rfn), .hsi_req_i(hreq),
    .ser_start_i(ev[1]), .ser_addr_i(ev[2]), .ser_frame_i(ev[3]),
    .twi_addr_i(ev[4]), .lptim_wake_i(ev[5]), .rtc_wake_i(ev[6]),
    .independent_watchdog_wake_i(ev[7]), .bor_wake_i(ev[8]), .port_a_line_zero_i(ev[9]),
    .port_a_line_two_i(ev[10]), .rst_pin_n_i(~ev[11]), .int_reset_i(irst),
    .main_regulator_o(mreg), .low_power_regulator_o(lpreg),
    .cpu_run_o(cpu), .flash_on_o(fl), .sram_on_o(sram),
    .sram_block_one_clk_o(c1), .sram_block_two_clk_o(c2),
    .radio_pwr_o(rpwr), .rng_en_o(random_number_generator), .pll_en_o(pll),
    .periph_run_o(prun), .opt_active_o(opt_act),
    .internal_16mhz_oscillator_o(osc16), .hsi_grant_o(grant),
    .external_32mhz_oscillator_o(osc32), .low_speed_osc_o(lso),
    .wake_irq_o(wirq), .wake_src_o(wsrc), .io_pull_o(pull_o),
    .io_analog_o(ana), .rst_pullup_o(rpu));

  lpmc_partner i_far (.core_clk_i(clk), .srst_i(srst), .go_i(go),
    .idx_i(idx), .dly_i(dly), .cpu_run_i(cpu), .ev_o(ev));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // mode is chosen before the wait pulse
  task automatic enter(input logic [2:0] m);
    mode = m;
    wait_s = 1'b1;
    tick(1);
    wait_s = 1'b0;
    tick(3);
  endtask

  // fire one event, count cycles to cpu release
  task automatic rouse(input logic [3:0] e);
    idx = e;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    n = 1;
    while (cpu !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    tick(4);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    chk("io_analog", 16'h1, ana);
    chk("opt_active", 16'h0, opt_act);
    srst = 1'b0;
    tick(3);
    chk("rst_pullup", 16'h1, rpu);
    irst = 1'b1;
    tick(3);
    chk("rst_pullup", 16'h0, rpu);
    irst = 1'b0;
    opt_en = 5'h15;
    tick(3);
    chk("opt_active", 16'h15, opt_act);
    $display("t_reset done");
  endtask

  task automatic t_sleep_lp;
    g1 = 1'b1;
    enter(3'h0);
    chk("sram_block_one_clk", 16'h0, c1);
    chk("sram_block_two_clk", 16'h1, c2);
    rouse(4'h0);
    chk("sleep wake", 16'h1, 16'(n <= 11));
    g1 = 1'b0;
    lp = 1'b1;
    tick(4);
    chk("lp regs", 16'h1, {mreg, lpreg});
    chk("rf rng pll", 16'h0, {rpwr, random_number_generator, pll});
    lp = 1'b0;
    fpd = 1'b1;
    csram = 1'b1;
    busy = 1'b1;
    tick(4);
    chk("flash busy", 16'h1, fl);
    busy = 1'b0;
    tick(4);
    chk("flash pd", 16'h0, fl);
    fpd = 1'b0;
    $display("t_sleep_lp done");
  endtask

  task automatic t_stop;
    enter(3'h1);
    hreq = 4'h4;
    tick(3);
    chk("hsi grant", 16'h4, grant);
    chk("osc16", 16'h1, osc16);
    hreq = 4'h0;
    tick(4);
    chk("osc16", 16'h0, osc16);
    for (int e = 1; e <= 3; e++) begin
      if (e > 1) enter(3'h1);
      rouse(e[3:0]);
      chk("stop0 time", 16'h1, 16'(n > 68 && n <= 74));
      chk("wake_src", 16'h1, wsrc);
    end
    enter(3'h2);
    rouse(4'h4);
    chk("stop1 time", 16'h1, 16'(n > 188 && n <= 194));
    chk("wake_src", 16'h2, wsrc);
    enter(3'h2);
    rfn = 1'b1;
    rouse(4'hf);
    rfn = 1'b0;
    chk("rf wake", 16'h1, cpu);
    $display("t_stop done");
  endtask

  task automatic t_standby;
    pull = 16'h9864;
    cfg = 1'b1;
    tick(1);
    cfg = 1'b0;
    retain = 1'b1;
    dly = 4'h3;
    enter(3'h3);
    chk("radio retain", 16'h1, rpwr);
    chk("io_pull", 16'h9864, pull_o);
    rouse(4'h9);
    chk("standby time", 16'h1, 16'(n >= SBY && n <= SBY + 11));
    chk("wake_src", 16'h3, wsrc);
    retain = 1'b0;
    enter(3'h3);
    chk("radio off", 16'h0, rpwr);
    rouse(4'h8);
    chk("wake_src", 16'h4, wsrc);
    dly = 4'h0;
    $display("t_standby done");
  endtask

  task automatic t_shutdown;
    enter(3'h4);
    chk("io_pull", 16'h9864, pull_o);
    chk("sram", 16'h0, sram);
    rouse(4'ha);
    chk("wake_src", 16'h3, wsrc);
    chk("io_pull", 16'h0, pull_o);
    chk("io_analog", 16'h1, ana);
    enter(3'h4);
    rouse(4'hb);
    chk("wake_src", 16'h4, wsrc);
    $display("t_shutdown done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    tick(2);
    t_reset();
    t_sleep_lp();
    t_stop();
    t_standby();
    t_shutdown();
    wrap_up();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
